// [vmsc_setup_control.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - After channel-2 enable, wait the settling time before its compare output enable.
// - With filter, wait one oscillator cycle after compare output enable before filter enable.
// - Filter is turned on by writing 0 to the filter-disable bit.
// - After filter enable, wait 2n + 3 oscillator cycles before relying on output.
// - Channel-1 setup starts by programming the four-bit level select field.
// - Selectable-input variant: both channel-1 input select bits written to 0.
// - Filtered variant: write filter divider, or set filter-disable when unused.
// - Interrupt-or-reset select is written 0 to get an interrupt.
// - Two-bit interrupt timing field is programmed; device raises interrupts accordingly.
// - Interrupt type bit is programmed before enable; device issues that type.
// - Detection enable is set only after level, input, filter, interrupt settings.
// - After channel-1 enable, wait settling time, then set compare output enable.
// - Unfiltered variant waits at least 2 us after channel-1 compare output enable.
// - After the waits, clear the detect flag, then set interrupt/reset enable.
module vmsc_setup_control
  import vmsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq,
  input wire logic lowSpeedOscClock,
  output logic devWrite,
  output logic [2:0] devAddr,
  output logic [7:0] devWdata
);

  vmsc_wait_if wt ();
  logic oscTick;

  vmsc_osc_tick oscSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .oscPin(lowSpeedOscClock),
    .tick(oscTick)
  );

  vmsc_wait_timer waitTimer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .oscTick(oscTick),
    .wt(wt.timer)
  );

  vmsc_state_t state;
  logic [3:0] ctrlMode;
  logic [10:0] cfg;
  logic [3:0] runMode;
  logic [10:0] runCfg;
  logic [7:0] cmpShadow;
  logic [7:0] ch1Cr0;
  logic [7:0] ch2Cr0;
  logic [1:0] irqStatus;
  logic [1:0] irqEnable;
  logic doneEvent;
  logic refusedEvent;
  logic startReq;
  logic startOsc;
  logic [7:0] startCount;
  logic timerGo;

  // Divider code 0..3 gives n = 1, 2, 4, 8, so 2n + 3 oscillator cycles.
  function automatic logic [7:0] filt_wait(input logic [1:0] divCode);
    filt_wait = (8'h02 << divCode) + 8'(FILT_SETTLE_ADD);
  endfunction

  wire logic useF1 = runMode[CTRL_CH1_FILTER_USE - 1];
  wire logic useF2 = runMode[CTRL_CH2_FILTER_USE - 1];
  wire logic selInputs = runMode[CTRL_SELECTABLE_INPUTS - 1];
  wire logic filtVariant = runMode[CTRL_FILTERED_VARIANT - 1];
  wire logic [1:0] div1 = runCfg[CFG_CH1_DIV_LSB +: 2];
  wire logic [1:0] div2 = runCfg[CFG_CH2_DIV_LSB +: 2];

  assign startReq = regWrite && regAddr == REG_CTRL && regWdata[CTRL_START];
  assign wt.start = timerGo;
  assign wt.useOsc = startOsc;
  assign wt.count = startCount;

  // Software registers.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrlMode <= 4'h0;
      cfg <= CFG_RESET;
      irqEnable <= 2'h0;
    end else if (regWrite) begin
      if (regAddr == REG_CTRL) begin
        ctrlMode <= regWdata[CTRL_FILTERED_VARIANT:CTRL_CH1_FILTER_USE];
      end
      if (regAddr == REG_CONFIG) begin
        cfg <= regWdata[10:0];
      end
      if (regAddr == REG_IRQ_ENABLE) begin
        irqEnable <= regWdata[1:0];
      end
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        REG_CTRL: regRdata <= {27'h0000000, ctrlMode, 1'b0};
        REG_CONFIG: regRdata <= {21'h000000, cfg};
        REG_STATUS: regRdata <= {23'h000000, state, 2'h0, (state != VMSC_IDLE)};
        REG_IRQ_STATUS: regRdata <= {30'h00000000, irqStatus};
        REG_IRQ_ENABLE: regRdata <= {30'h00000000, irqEnable};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // A new event wins over a clear that lands in the same cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStatus <= 2'h0;
      irq <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~((regWrite && regAddr == REG_IRQ_CLEAR) ? regWdata[1:0] : 2'h0))
                   | {refusedEvent, doneEvent};
      irq <= |(irqStatus & irqEnable);
    end
  end

  // Setup sequencer: one device write per write state, timed waits in between.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= VMSC_IDLE;
      runMode <= 4'h0;
      runCfg <= CFG_RESET;
      cmpShadow <= DEV_REG_RESET;
      ch1Cr0 <= DEV_REG_RESET;
      ch2Cr0 <= DEV_REG_RESET;
      devWrite <= 1'b0;
      devAddr <= DEV_LEVEL_SELECT;
      devWdata <= DEV_REG_RESET;
      timerGo <= 1'b0;
      startOsc <= 1'b0;
      startCount <= 8'h00;
      doneEvent <= 1'b0;
      refusedEvent <= 1'b0;
    end else begin
      devWrite <= 1'b0;
      timerGo <= 1'b0;
      doneEvent <= 1'b0;
      refusedEvent <= 1'b0;
      case (state)
        VMSC_IDLE: begin
          if (startReq) begin
            // Settings are frozen at start so a rewrite mid-sequence cannot tear them.
            runMode <= regWdata[CTRL_FILTERED_VARIANT:CTRL_CH1_FILTER_USE];
            runCfg <= cfg;
            state <= VMSC_C2_ENABLE;
          end
        end
        VMSC_C2_ENABLE: begin
          cmpShadow[CMP_CH2_DETECT_EN] <= 1'b1;
          devWrite <= 1'b1;
          devAddr <= DEV_COMPARATOR_CONTROL;
          devWdata <= cmpShadow | (8'h01 << CMP_CH2_DETECT_EN);
          timerGo <= 1'b1;
          startOsc <= 1'b0;
          startCount <= 8'(ENABLE_SETTLE_CYC);
          state <= VMSC_C2_SETTLE;
        end
        VMSC_C2_SETTLE: begin
          if (wt.done) begin
            state <= VMSC_C2_CMPE;
          end
        end
        VMSC_C2_CMPE: begin
          ch2Cr0[CR0_COMPARE_OUT_EN] <= 1'b1;
          ch2Cr0[CR0_FILTER_DISABLE] <= 1'b1;
          ch2Cr0[CR0_DIV_LSB +: 2] <= div2;
          devWrite <= 1'b1;
          devAddr <= DEV_CH2_CONTROL0;
          devWdata <= {ch2Cr0[7:4], div2, 2'b11};
          if (useF2) begin
            timerGo <= 1'b1;
            startOsc <= 1'b1;
            startCount <= 8'(OSC_GAP_CYC);
            state <= VMSC_C2_GAP;
          end else begin
            state <= VMSC_C1_LEVEL;
          end
        end
        VMSC_C2_GAP: begin
          if (wt.done) begin
            state <= VMSC_C2_FILT;
          end
        end
        VMSC_C2_FILT: begin
          ch2Cr0[CR0_FILTER_DISABLE] <= 1'b0;
          devWrite <= 1'b1;
          devAddr <= DEV_CH2_CONTROL0;
          devWdata <= ch2Cr0 & ~(8'h01 << CR0_FILTER_DISABLE);
          timerGo <= 1'b1;
          startOsc <= 1'b1;
          startCount <= filt_wait(div2);
          state <= VMSC_C2_FWAIT;
        end
        VMSC_C2_FWAIT: begin
          if (wt.done) begin
            state <= VMSC_C1_LEVEL;
          end
        end
        VMSC_C1_LEVEL: begin
          devWrite <= 1'b1;
          devAddr <= DEV_LEVEL_SELECT;
          devWdata <= {4'h0, runCfg[CFG_LEVEL_LSB +: 4]};
          state <= VMSC_C1_INPUT;
        end
        VMSC_C1_INPUT: begin
          if (selInputs) begin
            cmpShadow[CMP_CH1_EXT_REF] <= 1'b0;
            cmpShadow[CMP_CH1_EXT_IN] <= 1'b0;
            devWrite <= 1'b1;
            devAddr <= DEV_COMPARATOR_CONTROL;
            devWdata <= cmpShadow & ~8'h03;
          end
          state <= VMSC_C1_CR0;
        end
        VMSC_C1_CR0: begin
          // Filter-disable is written as filtVariant here; on the filtered variant the filter is switched on only after the compare output settles.
          ch1Cr0[CR0_DIV_LSB +: 2] <= div1;
          ch1Cr0[CR0_FILTER_DISABLE] <= filtVariant;
          ch1Cr0[CR0_INT_OR_RESET] <= 1'b0;
          devWrite <= 1'b1;
          devAddr <= DEV_CH1_CONTROL0;
          devWdata <= {ch1Cr0[7:5], 1'b0, div1, filtVariant, ch1Cr0[0]};
          state <= VMSC_C1_CR1;
        end
        VMSC_C1_CR1: begin
          devWrite <= 1'b1;
          devAddr <= DEV_CH1_CONTROL1;
          devWdata <= {5'h00, runCfg[CFG_TYPE], runCfg[CFG_TIMING_LSB +: 2]};
          state <= VMSC_C1_ENABLE;
        end
        VMSC_C1_ENABLE: begin
          cmpShadow[CMP_CH1_DETECT_EN] <= 1'b1;
          devWrite <= 1'b1;
          devAddr <= DEV_COMPARATOR_CONTROL;
          devWdata <= cmpShadow | (8'h01 << CMP_CH1_DETECT_EN);
          timerGo <= 1'b1;
          startOsc <= 1'b0;
          startCount <= 8'(ENABLE_SETTLE_CYC);
          state <= VMSC_C1_SETTLE;
        end
        VMSC_C1_SETTLE: begin
          if (wt.done) begin
            state <= VMSC_C1_CMPE;
          end
        end
        VMSC_C1_CMPE: begin
          ch1Cr0[CR0_COMPARE_OUT_EN] <= 1'b1;
          devWrite <= 1'b1;
          devAddr <= DEV_CH1_CONTROL0;
          devWdata <= ch1Cr0 | (8'h01 << CR0_COMPARE_OUT_EN);
          if (!filtVariant) begin
            timerGo <= 1'b1;
            startOsc <= 1'b0;
            startCount <= 8'(CMP_SETTLE_CYC);
            state <= VMSC_C1_POST;
          end else if (useF1) begin
            timerGo <= 1'b1;
            startOsc <= 1'b1;
            startCount <= 8'(OSC_GAP_CYC);
            state <= VMSC_C1_POST;
          end else begin
            state <= VMSC_C1_CLRDET;
          end
        end
        VMSC_C1_POST: begin
          if (wt.done) begin
            state <= (filtVariant && useF1) ? VMSC_C1_FILT : VMSC_C1_CLRDET;
          end
        end
        VMSC_C1_FILT: begin
          ch1Cr0[CR0_FILTER_DISABLE] <= 1'b0;
          devWrite <= 1'b1;
          devAddr <= DEV_CH1_CONTROL0;
          devWdata <= ch1Cr0 & ~(8'h01 << CR0_FILTER_DISABLE);
          timerGo <= 1'b1;
          startOsc <= 1'b1;
          startCount <= filt_wait(div1);
          state <= VMSC_C1_FWAIT;
        end
        VMSC_C1_FWAIT: begin
          if (wt.done) begin
            state <= VMSC_C1_CLRDET;
          end
        end
        VMSC_C1_CLRDET: begin
          devWrite <= 1'b1;
          devAddr <= DEV_CH1_STATUS;
          devWdata <= 8'h00;
          state <= VMSC_C1_RIE;
        end
        VMSC_C1_RIE: begin
          ch1Cr0[CR0_INT_RESET_EN] <= 1'b1;
          devWrite <= 1'b1;
          devAddr <= DEV_CH1_CONTROL0;
          devWdata <= ch1Cr0 | (8'h01 << CR0_INT_RESET_EN);
          doneEvent <= 1'b1;
          state <= VMSC_IDLE;
        end
        default: begin
          state <= VMSC_IDLE;
        end
      endcase
      if (startReq && state != VMSC_IDLE) begin
        refusedEvent <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [vmsc_pkg.sv]
package vmsc_pkg;

  // Clock of the controller.
  localparam int CLK_PERIOD_NS = 40;

  // Enable-to-active settling time of a detection circuit, in ns.
  localparam int ENABLE_SETTLE_NS = 300;
  localparam int ENABLE_SETTLE_CYC = (ENABLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Settling wait after the channel-1 compare output enable on the unfiltered variant.
  localparam int CMP_SETTLE_NS = 2000;
  localparam int CMP_SETTLE_CYC = (CMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Oscillator cycles to wait between compare output enable and filter enable.
  localparam int OSC_GAP_CYC = 1;
  // Filter settling is 2n + 3 oscillator cycles.
  localparam int FILT_SETTLE_ADD = 3;

  // Device register map, as seen on the device write port.
  localparam logic [2:0] DEV_LEVEL_SELECT = 3'h0;
  localparam logic [2:0] DEV_COMPARATOR_CONTROL = 3'h1;
  localparam logic [2:0] DEV_CH1_CONTROL0 = 3'h2;
  localparam logic [2:0] DEV_CH1_CONTROL1 = 3'h3;
  localparam logic [2:0] DEV_CH2_CONTROL0 = 3'h4;
  localparam logic [2:0] DEV_CH1_STATUS = 3'h5;

  // Comparator control bits.
  localparam int CMP_CH1_EXT_REF = 0;
  localparam int CMP_CH1_EXT_IN = 1;
  localparam int CMP_CH1_DETECT_EN = 2;
  localparam int CMP_CH2_DETECT_EN = 3;
  // Channel control 0 bits, shared layout for both channels.
  localparam int CR0_COMPARE_OUT_EN = 0;
  localparam int CR0_FILTER_DISABLE = 1;
  localparam int CR0_DIV_LSB = 2;
  localparam int CR0_INT_OR_RESET = 4;
  localparam int CR0_INT_RESET_EN = 5;
  // Channel 1 control 1 fields.
  localparam int CR1_TIMING_LSB = 0;
  localparam int CR1_TYPE = 2;
  localparam logic [7:0] DEV_REG_RESET = 8'h00;

  // Controller registers on the software port (byte offsets).
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CONFIG = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] REG_IRQ_CLEAR = 5'h10;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h14;

  // CTRL bits.
  localparam int CTRL_START = 0;
  localparam int CTRL_CH1_FILTER_USE = 1;
  localparam int CTRL_CH2_FILTER_USE = 2;
  localparam int CTRL_SELECTABLE_INPUTS = 3;
  localparam int CTRL_FILTERED_VARIANT = 4;
  // CONFIG fields.
  localparam int CFG_LEVEL_LSB = 0;
  localparam int CFG_CH1_DIV_LSB = 4;
  localparam int CFG_CH2_DIV_LSB = 6;
  localparam int CFG_TIMING_LSB = 8;
  localparam int CFG_TYPE = 10;
  localparam logic [10:0] CFG_RESET = 11'h000;
  // Interrupt event bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;

  typedef enum logic [4:0] {
    VMSC_IDLE = 5'h00,
    VMSC_C2_ENABLE = 5'h01,
    VMSC_C2_SETTLE = 5'h02,
    VMSC_C2_CMPE = 5'h03,
    VMSC_C2_GAP = 5'h04,
    VMSC_C2_FILT = 5'h05,
    VMSC_C2_FWAIT = 5'h06,
    VMSC_C1_LEVEL = 5'h07,
    VMSC_C1_INPUT = 5'h08,
    VMSC_C1_CR0 = 5'h09,
    VMSC_C1_CR1 = 5'h0A,
    VMSC_C1_ENABLE = 5'h0B,
    VMSC_C1_SETTLE = 5'h0C,
    VMSC_C1_CMPE = 5'h0D,
    VMSC_C1_POST = 5'h0E,
    VMSC_C1_FILT = 5'h0F,
    VMSC_C1_FWAIT = 5'h10,
    VMSC_C1_CLRDET = 5'h11,
    VMSC_C1_RIE = 5'h12
  } vmsc_state_t;

endpackage

// [vmsc_wait_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface vmsc_wait_if;
  logic start;
  logic useOsc;
  logic [7:0] count;
  logic done;
  modport ctrl (output start, output useOsc, output count, input done);
  modport timer (input start, input useOsc, input count, output done);
endinterface
`default_nettype wire

// [vmsc_osc_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module vmsc_osc_tick (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic oscPin,
  output logic tick
);
  logic syncA;
  logic syncB;
  logic lastB;

  // The oscillator is asynchronous, so it is resynchronised before its edge is taken.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      lastB <= 1'b0;
      tick <= 1'b0;
    end else begin
      syncA <= oscPin;
      syncB <= syncA;
      lastB <= syncB;
      tick <= syncB & ~lastB;
    end
  end
endmodule
`default_nettype wire

// [vmsc_wait_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module vmsc_wait_timer (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic oscTick,
  vmsc_wait_if.timer wt
);
  logic [8:0] remain;
  logic running;
  logic mode;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      remain <= 9'h000;
      running <= 1'b0;
      mode <= 1'b0;
      wt.done <= 1'b0;
    end else begin
      wt.done <= 1'b0;
      if (wt.start) begin
        // The first oscillator edge may come at once, so one extra edge makes a whole cycle.
        remain <= wt.useOsc ? {1'b0, wt.count} + 9'h001 : {1'b0, wt.count};
        mode <= wt.useOsc;
        running <= 1'b1;
      end else if (running) begin
        if (remain == 9'h000) begin
          running <= 1'b0;
          wt.done <= 1'b1;
        end else if (!mode || oscTick) begin
          remain <= remain - 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [vmsc_setup_control_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module vmsc_setup_control_properties
  import vmsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic lowSpeedOscClock,
  input wire logic devWrite,
  input wire logic [2:0] devAddr,
  input wire logic [7:0] devWdata
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic oscQ;
  logic [7:0] gap;
  logic [7:0] oscSince;
  logic [2:0] prevAddr;
  logic [7:0] prevData;
  logic filtOn;
  logic [3:0] filtN;
  logic [2:0] seen;
  logic cmpeUnfilt;
  wire logic cr0 = devWrite && (devAddr == DEV_CH1_CONTROL0 || devAddr == DEV_CH2_CONTROL0);
  wire logic fdClear = cr0 && !devWdata[CR0_FILTER_DISABLE] && prevAddr == devAddr
    && prevData[CR0_FILTER_DISABLE];
  wire logic ch1Cmpe = devWrite && devAddr == DEV_CH1_CONTROL0
    && prevAddr == DEV_COMPARATOR_CONTROL && prevData[CMP_CH1_DETECT_EN];
  // Raw oscillator edges are counted, so the count can only run ahead of a synchronised one.
  always_ff @(posedge mclk) begin
    oscQ <= lowSpeedOscClock;
    if (sys_rst || devWrite) begin
      oscSince <= 8'h00;
    end else if (lowSpeedOscClock && !oscQ && oscSince != 8'hFF) begin
      oscSince <= oscSince + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gap <= 8'h00;
      prevAddr <= 3'h0;
      prevData <= 8'h00;
    end else if (devWrite) begin
      gap <= 8'h01;
      prevAddr <= devAddr;
      prevData <= devWdata;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      filtOn <= 1'b0;
      filtN <= 4'h1;
      cmpeUnfilt <= 1'b0;
    end else if (devWrite) begin
      filtOn <= fdClear;
      filtN <= 4'h1 << devWdata[3:2];
      cmpeUnfilt <= ch1Cmpe && !devWdata[CR0_FILTER_DISABLE];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seen <= 3'h0;
    end else if (devWrite) begin
      seen <= seen | {devAddr == DEV_CH1_CONTROL1, devAddr == DEV_CH1_CONTROL0,
        devAddr == DEV_LEVEL_SELECT};
    end
  end
  sequence s_ch2_on;
    devWrite && devAddr == DEV_COMPARATOR_CONTROL && devWdata[CMP_CH2_DETECT_EN]
      && !devWdata[CMP_CH1_DETECT_EN];
  endsequence
  sequence s_ch1_on;
    devWrite && devAddr == DEV_COMPARATOR_CONTROL && devWdata[CMP_CH1_DETECT_EN];
  endsequence
  sequence s_rie_set;
    devWrite && devAddr == DEV_CH1_CONTROL0 && devWdata[CR0_INT_RESET_EN];
  endsequence
  chk_ch2_settle_wait: assert property (s_ch2_on |=> !(devWrite && devAddr == DEV_CH2_CONTROL0) [*8])
    else $error("channel 2 compare enabled too early");
  chk_filter_osc_gap: assert property (fdClear |-> oscSince >= OSC_GAP_CYC)
    else $error("filter enabled without an oscillator cycle");
  chk_filter_settle: assert property (devWrite && filtOn |-> oscSince >= 2 * filtN + FILT_SETTLE_ADD)
    else $error("filter settling cut short");
  chk_input_select: assert property (devWrite && devAddr == DEV_COMPARATOR_CONTROL |-> devWdata[1:0] == 2'h0)
    else $error("external input select set");
  chk_irq_not_reset: assert property (devWrite && devAddr == DEV_CH1_CONTROL0 |-> !devWdata[CR0_INT_OR_RESET])
    else $error("reset selected instead of interrupt");
  chk_enable_order: assert property (s_ch1_on |-> seen == 3'h7)
    else $error("channel 1 enabled before setup");
  chk_ch1_settle_wait: assert property (ch1Cmpe |-> gap >= ENABLE_SETTLE_CYC)
    else $error("channel 1 compare enabled too early");
  chk_cmp_settle_wait: assert property (devWrite && cmpeUnfilt |-> gap >= CMP_SETTLE_CYC)
    else $error("compare settling cut short");
  chk_flag_before_enable: assert property (s_rie_set |-> prevAddr == DEV_CH1_STATUS && prevData == 8'h00)
    else $error("interrupt enabled before flag clear");
endmodule
bind vmsc_setup_control vmsc_setup_control_properties u_chk (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .lowSpeedOscClock(lowSpeedOscClock),
  .devWrite(devWrite),
  .devAddr(devAddr),
  .devWdata(devWdata)
);
`default_nettype wire

// [vmsc_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vmsc_dev_model
  import vmsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic devWrite,
  input wire logic [2:0] devAddr,
  input wire logic [7:0] devWdata,
  output logic lowSpeedOscClock,
  output logic devIrq,
  output logic filtTick
);
  logic [7:0] regs [0:5];
  logic [2:0] div = 3'h0;
  initial lowSpeedOscClock = 1'b0;
  // The oscillator runs free, at a rate unrelated to the controller clock.
  always #487 lowSpeedOscClock = ~lowSpeedOscClock;
  // Timing and type fields are held as written; devIrq does not depend on them.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 6; i++) begin
        regs[i] <= DEV_REG_RESET;
      end
    end else if (devWrite && devAddr < 3'h6) begin
      regs[devAddr] <= devWdata;
    end
  end
  always @(posedge lowSpeedOscClock) begin
    div <= (div + 3'h1) & ((3'h1 << regs[DEV_CH1_CONTROL0][3:2]) - 3'h1);
    filtTick <= div == 3'h0;
  end
  assign devIrq = regs[DEV_COMPARATOR_CONTROL][CMP_CH1_DETECT_EN]
    && regs[DEV_CH1_CONTROL0][CR0_COMPARE_OUT_EN] && regs[DEV_CH1_CONTROL0][CR0_INT_RESET_EN];
endmodule
`default_nettype wire

// [test_voltage_monitor_setup_control.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_voltage_monitor_setup_control;
  import vmsc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic rdPend = 1'b0;
  wire logic [31:0] regRdata;
  wire logic irq, osc, devWrite, devIrq;
  wire logic [2:0] devAddr;
  wire logic [7:0] devWdata;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 80541;
  logic [31:0] rq [$];
  logic [10:0] dq [$];
  always #20 mclk = ~mclk;
  vmsc_setup_control u_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .irq(irq), .lowSpeedOscClock(osc), .devWrite(devWrite), .devAddr(devAddr),
    .devWdata(devWdata));
  vmsc_dev_model u_dev (.mclk(mclk), .sys_rst(sys_rst), .devWrite(devWrite), .devAddr(devAddr),
    .devWdata(devWdata), .lowSpeedOscClock(osc), .devIrq(devIrq), .filtTick());
  task results;
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    rq.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  task dexp(input logic [2:0] a, input logic [7:0] d);
    dq.push_back({a, d});
  endtask
  // Sampled on the falling edge, where the level has settled.
  task waitIrq(input logic w, input int lim);
    for (int i = 0; i < lim && irq !== w; i++) @(negedge mclk);
    if (irq !== w) begin
      n_mismatch++;
      results();
    end
  endtask
  always @(posedge mclk) begin
    logic [31:0] e;
    logic [10:0] f;
    if (rdPend) begin
      e = rq.pop_front();
      `CHK("regRdata", e, regRdata)
    end
    rdPend <= regRead;
    if (devWrite === 1'b1) begin
      f = dq.size() > 0 ? dq.pop_front() : 11'h7FF;
      `CHK("devWrite", f, {devAddr, devWdata})
    end
  end
  initial begin
    logic [3:0] modes [4];
    logic [3:0] m;
    logic [3:0] lvl;
    logic [7:0] c0;
    logic [1:0] v;
    modes = '{4'h0, 4'hF, 4'hA, 4'h5};
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      m = modes[k];
      v = k[1:0];
      lvl = $random(seed);
      rd(REG_CONFIG, {21'h0, CFG_RESET});
      rd(5'h1C, 32'h0);
      wr(5'h1C, 32'hFFFFFFFF);
      wr(REG_IRQ_ENABLE, 32'h1);
      wr(REG_CONFIG, {21'h0, v[0], v, v, v, lvl});
      dexp(DEV_COMPARATOR_CONTROL, 8'h08);
      dexp(DEV_CH2_CONTROL0, {4'h0, v, 2'h3});
      if (m[1]) dexp(DEV_CH2_CONTROL0, {4'h0, v, 2'h1});
      dexp(DEV_LEVEL_SELECT, {4'h0, lvl});
      if (m[2]) dexp(DEV_COMPARATOR_CONTROL, 8'h08);
      c0 = {4'h0, v, m[3], 1'b0};
      dexp(DEV_CH1_CONTROL0, c0);
      dexp(DEV_CH1_CONTROL1, {5'h0, v[0], v});
      dexp(DEV_COMPARATOR_CONTROL, 8'h0C);
      c0[0] = 1'b1;
      dexp(DEV_CH1_CONTROL0, c0);
      if (m[3] && m[0]) begin
        c0[1] = 1'b0;
        dexp(DEV_CH1_CONTROL0, c0);
      end
      dexp(DEV_CH1_STATUS, 8'h00);
      c0[5] = 1'b1;
      dexp(DEV_CH1_CONTROL0, c0);
      // A second start while busy must be refused and leave the run alone.
      wr(REG_CTRL, {27'h0, m, 1'b1});
      wr(REG_CTRL, {27'h0, m, 1'b1});
      rd(REG_CTRL, {27'h0, m, 1'b0});
      waitIrq(1'b1, 20000);
      rd(REG_IRQ_STATUS, 32'h3);
      `CHK("devIrq", 1'b1, devIrq)
      `CHK("pending", 32'd0, dq.size())
      wr(REG_IRQ_ENABLE, 32'h0);
      waitIrq(1'b0, 3);
      wr(REG_IRQ_ENABLE, 32'h1);
      waitIrq(1'b1, 3);
      wr(REG_IRQ_CLEAR, 32'h3);
      waitIrq(1'b0, 3);
      rd(REG_IRQ_STATUS, 32'h0);
    end
    repeat (2) @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
